// >>> core/spi_irq_params.svh
// Purpose: Offsets, field positions, reset values and widths of the interrupt enable block
// Assumes: Included by bare name, guarded against double inclusion
// Notes:   Definitions only
`ifndef SPI_IRQ_PARAMS_SVH
`define SPI_IRQ_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define STATUS_OFFSET       8'h20
`define ENABLE_OFFSET       8'h28
`define ENABLE_RESET        32'h0000_0000
`define STATUS_RESET        14'h0000
`define FLAG_COUNT          14

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_MASTER_FAULT    0
`define BIT_SLAVE_FAULT     1
`define BIT_TX_EMPTY        2
`define BIT_TX_UNDERRUN     3
`define BIT_RX_FULL         4
`define BIT_RX_OVERRUN      5
`define BIT_TX_HALF_EMPTY   6
`define BIT_SELECT_ASSERTED 7
`define BIT_RX_NOT_EMPTY    8
`define BIT_LANE_LOW        9
`define BIT_LANE_HIGH       13

`endif

// >>> core/spi_irq_pkg.sv
// Purpose: Types shared by the interrupt enable block
// Assumes: Flag count matches the header
// Notes:   Types only
package spi_irq_pkg;
  typedef logic [13:0] flag_vec_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  offset_t;
endpackage

// >>> core/flag_qualifier.sv
// Purpose: Per-bit qualification of enable bits by core configuration
// Assumes: Configuration inputs are static straps on the same clock
// Notes:   Purely combinational
`include "spi_irq_params.svh"
module flag_qualifier
  import spi_irq_pkg::*;
(
  input  wire logic      multi_lane_i,
  input  wire logic      fifo_present_i,
  input  wire logic      fifo_depth_one_i,
  input  wire logic      slave_mode_i,
  output logic [13:0]    allow_o
);
  // ****************************************************************
  // Allowed positions
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `FLAG_COUNT; g++) begin : g_allow
      if (g >= `BIT_LANE_LOW && g <= `BIT_LANE_HIGH) begin : g_lane
        assign allow_o[g] = multi_lane_i;
      end else if (g == `BIT_RX_NOT_EMPTY) begin : g_rne
        assign allow_o[g] = fifo_depth_one_i & slave_mode_i & ~multi_lane_i;
      end else if (g == `BIT_SELECT_ASSERTED) begin : g_sel
        assign allow_o[g] = slave_mode_i;
      end else if (g == `BIT_TX_HALF_EMPTY) begin : g_half
        assign allow_o[g] = fifo_present_i;
      end else begin : g_plain
        assign allow_o[g] = 1'b1;
      end
    end
  endgenerate
endmodule

// >>> core/spi_interrupt_enable_mask.sv
// Purpose: Interrupt status and enable registers with gated system interrupt output
// Assumes: Register port on mclk_i; event strobes come from core logic on the same clock
// Notes:   Reads return data one cycle after the read strobe
`include "spi_irq_params.svh"
module spi_interrupt_enable_mask
  import spi_irq_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_b_i,
  input  wire logic      reg_wr_i,
  input  wire logic      reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]    reg_rdata_o,
  input  wire logic [13:0] event_strobe_i,
  input  wire logic      multi_lane_i,
  input  wire logic      fifo_present_i,
  input  wire logic      fifo_depth_one_i,
  input  wire logic      slave_mode_i,
  output logic [13:0]    interrupt_status_o,
  output logic           irq_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  flag_vec_t interrupt_enable_reg;
  flag_vec_t interrupt_enable_next;
  flag_vec_t interrupt_status_reg;
  flag_vec_t interrupt_status_next;
  word_t     rdata_reg;
  word_t     rdata_next;
  logic      irq_reg;
  logic      irq_next;
  flag_vec_t allow;
  flag_vec_t en_mask;
  logic      wr_en;
  logic      wr_st;
  logic      rd_en;
  logic      rd_st;

  flag_qualifier u_qual (
    .multi_lane_i     (multi_lane_i),
    .fifo_present_i   (fifo_present_i),
    .fifo_depth_one_i (fifo_depth_one_i),
    .slave_mode_i     (slave_mode_i),
    .allow_o          (allow)
  );

  // ****************************************************************
  // Register decode
  // ****************************************************************
  always_comb begin
    wr_en = reg_wr_i && (reg_addr_i == `ENABLE_OFFSET);
    wr_st = reg_wr_i && (reg_addr_i == `STATUS_OFFSET);
    rd_en = reg_rd_i && (reg_addr_i == `ENABLE_OFFSET);
    rd_st = reg_rd_i && (reg_addr_i == `STATUS_OFFSET);
  end

  // ****************************************************************
  // Enable register
  // ****************************************************************
  always_comb begin
    interrupt_enable_next = interrupt_enable_reg;
    if (wr_en) begin
      interrupt_enable_next = reg_wdata_i[13:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_enable_reg <= flag_vec_t'(`ENABLE_RESET);
    end else begin
      interrupt_enable_reg <= interrupt_enable_next;
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************
  always_comb begin
    interrupt_status_next = interrupt_status_reg;
    if (wr_st) begin
      interrupt_status_next = interrupt_status_reg ^ reg_wdata_i[13:0];
    end
    interrupt_status_next = interrupt_status_next | event_strobe_i;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_status_reg <= `STATUS_RESET;
    end else begin
      interrupt_status_reg <= interrupt_status_next;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_en) begin
      rdata_next = {18'h0_0000, interrupt_enable_reg};
    end else if (rd_st) begin
      rdata_next = {18'h0_0000, interrupt_status_reg};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  always_comb begin
    en_mask  = interrupt_enable_reg & allow;
    irq_next = |(interrupt_status_reg & en_mask);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata_o        = rdata_reg;
  assign interrupt_status_o = interrupt_status_reg;
  assign irq_o              = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_needs_enable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_o |-> $past(|(interrupt_status_reg & interrupt_enable_reg)))
    else $error("Interrupt without enabled flag");
  a_irq_follows_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (|(interrupt_status_reg & en_mask)) |=> irq_o)
    else $error("Interrupt missing after enabled flag");
  a_enable_after_reset: assert property (@(posedge mclk_i)
    $rose(rst_b_i) |-> interrupt_enable_reg == 14'h0000)
    else $error("Enable not clear after reset");
  a_enable_write_lands: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (reg_wr_i && reg_addr_i == `ENABLE_OFFSET) |=> interrupt_enable_reg == $past(reg_wdata_i[13:0]))
    else $error("Enable write lost");
  a_lane_bits_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !multi_lane_i |-> en_mask[13:9] == 5'h00)
    else $error("Lane enables act in standard mode");
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    reg_rdata_o[31:14] == 18'h0_0000)
    else $error("Reserved bits not zero");
  a_rne_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !(fifo_depth_one_i && slave_mode_i) |-> !en_mask[8])
    else $error("Receive not empty enable acts wrongly");
  a_select_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !slave_mode_i |-> !en_mask[7])
    else $error("Select enable acts in master mode");
  a_half_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !fifo_present_i |-> !en_mask[6])
    else $error("Half empty enable acts without FIFOs");
  a_strobe_sets: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    event_strobe_i[3] |=> interrupt_status_reg[3])
    else $error("Strobe did not set flag");
  a_toggle_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_st && event_strobe_i == 14'h0000) |=>
      interrupt_status_reg == ($past(interrupt_status_reg) ^ $past(reg_wdata_i[13:0])))
    else $error("Status toggle wrong");
  a_fault_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (interrupt_status_reg == 14'h0001 && !interrupt_enable_reg[0]) |=> !irq_o)
    else $error("Master fault passed while disabled");
  a_irq_exact: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_o == $past(|(interrupt_status_reg & en_mask)))
    else $error("Interrupt output is not the registered OR of enabled flags");
  a_irq_masked_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ((interrupt_status_reg & en_mask) == 14'h0000) |=> !irq_o)
    else $error("Interrupt while no enabled flag is set");
  a_underrun_pass: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (interrupt_status_reg[3] && interrupt_enable_reg[3]) |=> irq_o)
    else $error("Enabled underrun flag gave no interrupt");
  a_empty_pass: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (interrupt_status_reg[2] && interrupt_enable_reg[2]) |=> irq_o)
    else $error("Enabled transmit empty flag gave no interrupt");
  a_slave_fault_pass: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (interrupt_status_reg[1] && interrupt_enable_reg[1]) |=> irq_o)
    else $error("Enabled slave fault flag gave no interrupt");
  a_enable_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !wr_en |=> $stable(interrupt_enable_reg))
    else $error("Enable changed without a write");
  a_enable_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rd_en |=> reg_rdata_o == {18'h0_0000, $past(interrupt_enable_reg)})
    else $error("Enable read data wrong");
  a_status_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rd_st |=> reg_rdata_o == {18'h0_0000, $past(interrupt_status_reg)})
    else $error("Status read data wrong");
  a_idle_read_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !(rd_en || rd_st) |=> reg_rdata_o == 32'h0000_0000)
    else $error("Read data not zero without a mapped read");
  a_status_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!wr_st && event_strobe_i == 14'h0000) |=> $stable(interrupt_status_reg))
    else $error("Status changed without write or strobe");

  // ****************************************************************
  // Per-flag checks
  // ****************************************************************
  genvar s;
  generate
    for (s = 0; s < `FLAG_COUNT; s++) begin : g_strobe_chk
      a_strobe_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        event_strobe_i[s] |=> interrupt_status_reg[s])
        else $error("Strobe did not set its flag");
    end
  endgenerate
endmodule

// >>> verification/irq_sink.sv
// Purpose: Model of the interrupt controller that takes the level request
// Assumes: Level request sampled on the bus clock
// Notes:   Counts each new request it takes
module irq_sink (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic irq_i,
  output int        taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen    <= 1'b0;
      taken_o <= 0;
    end else begin
      seen <= irq_i;
      if (irq_i && !seen) taken_o <= taken_o + 1;
    end
  end
endmodule

// >>> verification/spi_interrupt_enable_mask_tb.sv
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: Config straps change only between passes of the gating test
// Notes:   Reads queue expected {irq, data}; a monitor compares them
`include "spi_irq_params.svh"
module spi_interrupt_enable_mask_tb
  import spi_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, rd_seen = 0, irq_o;
  logic        multi_lane_i = 0, fifo_present_i = 0, fifo_depth_one_i = 0, slave_mode_i = 0;
  offset_t     reg_addr_i = '0;
  word_t       reg_wdata_i = '0, reg_rdata_o, rw, m;
  flag_vec_t   event_strobe_i = '0, interrupt_status_o;
  logic [32:0] exp_q[$];
  logic [15:0] lfsr = 16'hC344;
  int          num_errors = 0, num_checks = 0, edges, exp_edges = 0;
  // ********************
  // Design and partner
  // ********************
  spi_interrupt_enable_mask dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .event_strobe_i(event_strobe_i), .multi_lane_i(multi_lane_i), .fifo_present_i(fifo_present_i),
    .fifo_depth_one_i(fifo_depth_one_i), .slave_mode_i(slave_mode_i),
    .interrupt_status_o(interrupt_status_o), .irq_o(irq_o));
  irq_sink sink (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .irq_i(irq_o), .taken_o(edges));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] step(input logic [15:0] v);
    step = v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
  endfunction
  function automatic logic allowed(input int b);
    case (b)
      6:       allowed = fifo_present_i;
      7:       allowed = slave_mode_i;
      8:       allowed = fifo_depth_one_i & slave_mode_i & ~multi_lane_i;
      default: allowed = (b >= 9) ? multi_lane_i : 1'b1;
    endcase
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input offset_t a, input word_t d);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic rd(input offset_t a, input logic ei, input word_t ed);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back({ei, ed});
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    if (rd_seen) check({irq_o, reg_rdata_o}, exp_q.pop_front());
    rd_seen <= reg_rd_i;
  end
  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rd(`ENABLE_OFFSET, 1'b0, `ENABLE_RESET);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0000);
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      rw = {lfsr, step(lfsr)};
      lfsr = step(step(lfsr));
      wr(`ENABLE_OFFSET, rw);
      wr(8'h24, ~rw);
      rd(`ENABLE_OFFSET, 1'b0, rw & 32'h0000_3FFF);
      rd(8'h24, 1'b0, 32'h0000_0000);
    end
    $display("Test enable access done");
    wr(`ENABLE_OFFSET, 32'h0000_0000);
    wr(`STATUS_OFFSET, 32'h0000_0005);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0005);
    wr(`STATUS_OFFSET, 32'h0000_0000);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0005);
    wr(`STATUS_OFFSET, 32'h0000_0004);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0001);
    wr(`STATUS_OFFSET, 32'h0000_0001);
    $display("Test toggle done");
    for (int c = 0; c < 16; c++) begin
      {multi_lane_i, fifo_present_i, fifo_depth_one_i, slave_mode_i} <= c[3:0];
      for (int b = 0; b < `FLAG_COUNT; b++) begin
        m = 32'h0000_0001 << b;
        lfsr = step(lfsr);
        event_strobe_i <= m[13:0];
        @(posedge mclk_i);
        event_strobe_i <= '0;
        wr(`ENABLE_OFFSET, ~m);
        check({19'h0_0000, interrupt_status_o}, {1'b0, m});
        rd(`STATUS_OFFSET, 1'b0, m);
        wr(`ENABLE_OFFSET, m | {lfsr[15:2], 18'h0_0000});
        rd(`ENABLE_OFFSET, allowed(b), m);
        exp_edges += int'(allowed(b));
        wr(`STATUS_OFFSET, m);
        rd(`STATUS_OFFSET, 1'b0, 32'h0000_0000);
      end
    end
    $display("Test gating done");
    check({1'b0, word_t'(edges)}, {1'b0, word_t'(exp_edges)});
    event_strobe_i <= 14'h0001;
    @(posedge mclk_i);
    reg_wr_i       <= 1'b1;
    reg_addr_i     <= `STATUS_OFFSET;
    reg_wdata_i    <= 32'h0000_0001;
    @(posedge mclk_i);
    event_strobe_i <= '0;
    reg_wr_i       <= 1'b0;
    @(posedge mclk_i);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0001);
    wr(`STATUS_OFFSET, 32'h0000_0001);
    $display("Test set wins done");
    wr(`ENABLE_OFFSET, 32'h0000_3FFF);
    event_strobe_i <= 14'h3FFF;
    @(posedge mclk_i);
    event_strobe_i <= '0;
    rd(`STATUS_OFFSET, 1'b1, 32'h0000_3FFF);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rd(`ENABLE_OFFSET, 1'b0, `ENABLE_RESET);
    rd(`STATUS_OFFSET, 1'b0, 32'h0000_0000);
    $display("Test reset in run done");
    repeat (2) @(posedge mclk_i);
    check({1'b0, word_t'(exp_q.size())}, 33'h0_0000_0000);
    end_sim();
  end
endmodule
